// file: hw/isr_top.sv
// Operation
// - 32 of the 34 peripheral sources reach every channel gate
// - each channel has private source enables
// - channel OR gets its software trigger bit
// - set trigger bit asserts channel request
// - trigger bits change only by writes, reset
// - fixed priority, highest pending served first
// - every channel has its own mask bit
// - mapping taken from routing inputs, not cleared at reset, remappable any time
// - channels seen as active-high level requests
// - programmable inverter on each external input
// - internal sources keep native high polarity
// - one polarity setting per pin, shared by all channels
// - only 17 internal sources reach maskable channels
// - 18 internal sources may reach nmi
// - 23 trigger bits in two registers
// - fifteen external pins: eleven general, four pci
// - master inputs 2, 5 wired to slaves
// - legacy: second slave bypassed, P13 to IR5
// - clear port write clears request, sets ignne
// - ignne drops after ferr; reset clears both
// - disabled slave passes P3 or P13 through
// - sources reach nmi only on all-ones routing code; trigger bit 6 also sets nmi
`timescale 1ns/1ns
module isr_top
  import isr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // external interrupt pins
  input wire logic [10:0] general_irq_pins_i,
  input wire logic [3:0] pci_int_pins_i,
  // internal peripheral sources, same clock
  input wire logic [ISR_NUM_INT-1:0] internal_src_i,
  // processor floating-point error pin
  input wire logic ferr_i,
  // configuration
  input wire isr_pkg::isr_route_t [ISR_NUM_SRC-1:0] source_routing_fields_i,
  input wire logic [ISR_NUM_EXT-1:0] ext_invert_i,
  input wire logic [ISR_NUM_CHAN-1:0] chan_mask_i,
  input wire isr_pkg::isr_cascade_t cascade_i,
  // register access
  input wire isr_pkg::isr_mmcr_req_t mmcr_i,
  input wire isr_pkg::isr_io_req_t io_i,
  output logic [15:0] mmcr_rdata_o,
  output logic mmcr_rvalid_o,
  // toward the processor
  output logic [ISR_NUM_CHAN-1:0] chan_req_o,
  output logic [7:0] master_ir_o,
  output logic cpu_intr_o,
  output logic [4:0] active_chan_o,
  output logic nmi_req_o,
  output logic ignne_o
);

  logic [ISR_NUM_EXT-1:0] ext_sync;
  logic ferr_sync;
  logic [ISR_NUM_EXT-1:0] ext_level;
  logic [ISR_NUM_SRC-1:0] src_vec;
  logic [ISR_NUM_CHAN-1:0] chan_or;
  logic nmi_or;
  logic [7:0] master_ir_c;
  logic [4:0] winner_c;

  logic [15:0] sw_trigger_low_reg;
  logic [15:0] sw_trigger_low_next;
  logic [6:0] sw_trigger_high_reg;
  logic [6:0] sw_trigger_high_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  logic fpu_req_reg;
  logic fpu_req_next;
  logic ignne_reg;
  logic ignne_next;
  logic ferr_q_reg;
  logic ferr_q_next;

  logic [ISR_NUM_CHAN-1:0] chan_req_reg;
  logic [ISR_NUM_CHAN-1:0] chan_req_next;
  logic [7:0] master_ir_reg;
  logic [7:0] master_ir_next;
  logic cpu_intr_reg;
  logic cpu_intr_next;
  logic [4:0] active_chan_reg;
  logic [4:0] active_chan_next;
  logic nmi_reg;
  logic nmi_next;

  // routing field selects channel ch (1..22)
  function automatic logic route_hits(input isr_route_t r, input int ch);
    return r == 5'(ch);
  endfunction

  // source may reach a maskable channel
  function automatic logic src_maskable(input int s);
    return !(s == ISR_SRC_INT_BASE + ISR_INT_ECC_MULTI ||
             s == ISR_SRC_INT_BASE + ISR_INT_PCI_NMI);
  endfunction

  // source may reach the nmi gate
  function automatic logic src_nmi_ok(input int s);
    return s != ISR_SRC_INT_BASE + ISR_INT_ECC_SINGLE;
  endfunction

  // eleven general pins and four pci lines
  isr_sync #(
    .WIDTH(ISR_NUM_EXT)
  ) u_ext_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pci_int_pins_i, general_irq_pins_i}),
    .sync_o(ext_sync)
  );

  isr_sync #(
    .WIDTH(1)
  ) u_ferr_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ferr_i),
    .sync_o(ferr_sync)
  );

  always_comb begin
    // one inverter per pin, shared by all channels
    ext_level = ext_sync ^ ext_invert_i;
    src_vec = {internal_src_i, ext_level};
    src_vec[ISR_SRC_INT_BASE + ISR_INT_FPU_ERR] = fpu_req_reg;
  end

  // private enable per channel and source
  for (genvar c = 0; c < ISR_NUM_CHAN; c++) begin : g_chan
    logic [ISR_NUM_SRC-1:0] en;
    for (genvar s = 0; s < ISR_NUM_SRC; s++) begin : g_src
      assign en[s] = src_maskable(s) && route_hits(source_routing_fields_i[s], c + 1);
    end
    logic sw_bit;
    if (c < ISR_SW_LOW_W) begin : g_lo
      assign sw_bit = sw_trigger_low_reg[c];
    end else begin : g_hi
      assign sw_bit = sw_trigger_high_reg[c - ISR_SW_LOW_W];
    end
    // trigger bit is one more OR input
    assign chan_or[c] = |(src_vec & en) | sw_bit;
  end

  always_comb begin
    nmi_or = sw_trigger_high_reg[ISR_SW_NMI_BIT];
    for (int s = 0; s < ISR_NUM_SRC; s++) begin
      // nmi only on the all-ones code
      if (src_nmi_ok(s) && source_routing_fields_i[s] == ISR_ROUTE_NMI) begin
        nmi_or = nmi_or | src_vec[s];
      end
    end
  end

  isr_priority u_prio (
    .chan_req_i(chan_req_reg),
    .chan_mask_i(chan_mask_i),
    .cascade_i(cascade_i),
    .master_ir_o(master_ir_c),
    .winner_o(winner_c)
  );

  // software trigger registers and read port
  always_comb begin
    sw_trigger_low_next = sw_trigger_low_reg;
    sw_trigger_high_next = sw_trigger_high_reg;
    rdata_next = rdata_reg;
    rvalid_next = mmcr_i.rd;
    // only software writes change trigger bits
    if (mmcr_i.wr && mmcr_i.addr == ISR_SW_TRIG_LOW_OFS) begin
      sw_trigger_low_next = mmcr_i.wdata;
    end
    if (mmcr_i.wr && mmcr_i.addr == ISR_SW_TRIG_HIGH_OFS) begin
      sw_trigger_high_next = mmcr_i.wdata[ISR_SW_HIGH_W-1:0];
    end
    if (mmcr_i.rd) begin
      case (mmcr_i.addr)
        ISR_SW_TRIG_LOW_OFS: rdata_next = sw_trigger_low_reg;
        ISR_SW_TRIG_HIGH_OFS: rdata_next = {9'h000, sw_trigger_high_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_trigger_low_reg <= ISR_SW_LOW_RST;
      sw_trigger_high_reg <= ISR_SW_HIGH_RST;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      sw_trigger_low_reg <= sw_trigger_low_next;
      sw_trigger_high_reg <= sw_trigger_high_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // floating-point error request and ignne
  always_comb begin
    logic clr_wr;
    logic ferr_rise;
    clr_wr = io_i.wr && io_i.addr == ISR_FPU_CLR_PORT;
    ferr_rise = ferr_sync && !ferr_q_reg;
    ferr_q_next = ferr_sync;
    // clear port write drops request, new error wins
    fpu_req_next = ferr_rise | (fpu_req_reg & ~clr_wr);
    // ignne on write, off once ferr falls
    if (clr_wr) begin
      ignne_next = 1'b1;
    end else if (!ferr_sync) begin
      ignne_next = 1'b0;
    end else begin
      ignne_next = ignne_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fpu_req_reg <= 1'b0;
      ignne_reg <= 1'b0;
      ferr_q_reg <= 1'b0;
    end else begin
      fpu_req_reg <= fpu_req_next;
      ignne_reg <= ignne_next;
      ferr_q_reg <= ferr_q_next;
    end
  end

  // channel and processor-facing outputs
  always_comb begin
    chan_req_next = chan_or;
    master_ir_next = master_ir_c;
    cpu_intr_next = winner_c != 5'h00;
    active_chan_next = winner_c;
    nmi_next = nmi_or;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_req_reg <= '0;
      master_ir_reg <= 8'h00;
      cpu_intr_reg <= 1'b0;
      active_chan_reg <= 5'h00;
      nmi_reg <= 1'b0;
    end else begin
      chan_req_reg <= chan_req_next;
      master_ir_reg <= master_ir_next;
      cpu_intr_reg <= cpu_intr_next;
      active_chan_reg <= active_chan_next;
      nmi_reg <= nmi_next;
    end
  end

  assign mmcr_rdata_o = rdata_reg;
  assign mmcr_rvalid_o = rvalid_reg;
  assign chan_req_o = chan_req_reg;
  assign master_ir_o = master_ir_reg;
  assign cpu_intr_o = cpu_intr_reg;
  assign active_chan_o = active_chan_reg;
  assign nmi_req_o = nmi_reg;
  assign ignne_o = ignne_reg;

endmodule

// file: hw/isr_pkg.sv
package isr_pkg;

  localparam int ISR_NUM_CHAN = 22;
  localparam int ISR_NUM_EXT = 15;
  localparam int ISR_NUM_INT = 19;
  localparam int ISR_NUM_SRC = ISR_NUM_EXT + ISR_NUM_INT;
  localparam int ISR_ROUTE_W = 5;

  // source numbering: externals first, then internals
  localparam int ISR_SRC_INT_BASE = ISR_NUM_EXT;
  localparam int ISR_INT_PCI_NMI = 1;
  localparam int ISR_INT_ECC_SINGLE = 2;
  localparam int ISR_INT_ECC_MULTI = 3;
  localparam int ISR_INT_FPU_ERR = 18;

  // routing field codes
  localparam logic [4:0] ISR_ROUTE_NONE = 5'h00;
  localparam logic [4:0] ISR_ROUTE_NMI = 5'h1f;

  // memory-mapped trigger registers
  localparam logic [11:0] ISR_SW_TRIG_LOW_OFS = 12'hd08;
  localparam logic [11:0] ISR_SW_TRIG_HIGH_OFS = 12'hd0a;
  localparam int ISR_SW_LOW_W = 16;
  localparam int ISR_SW_HIGH_W = 7;
  localparam int ISR_SW_NMI_BIT = 6;
  localparam logic [15:0] ISR_SW_LOW_RST = 16'h0000;
  localparam logic [6:0] ISR_SW_HIGH_RST = 7'h00;

  // i/o port of the floating-point error clear
  localparam logic [15:0] ISR_FPU_CLR_PORT = 16'h00f0;

  // master inputs taken by the slave outputs
  localparam int ISR_MASTER_SLAVE1_IR = 2;
  localparam int ISR_MASTER_SLAVE2_IR = 5;

  typedef logic [ISR_ROUTE_W-1:0] isr_route_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } isr_mmcr_req_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } isr_io_req_t;

  typedef struct packed {
    logic slave1_off;
    logic slave2_off;
  } isr_cascade_t;

endpackage

// file: hw/isr_sync.sv
`timescale 1ns/1ns
module isr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule

// file: hw/isr_priority.sv
`timescale 1ns/1ns
module isr_priority
  import isr_pkg::*;
(
  // channel requests, bit 0 is P1
  input wire logic [ISR_NUM_CHAN-1:0] chan_req_i,
  input wire logic [ISR_NUM_CHAN-1:0] chan_mask_i,
  input wire isr_pkg::isr_cascade_t cascade_i,
  // master view and winner
  output logic [7:0] master_ir_o,
  output logic [4:0] winner_o
);

  logic [ISR_NUM_CHAN-1:0] live;
  logic [7:0] s1_ir;
  logic [7:0] s2_ir;

  // lowest set bit of an 8-input controller, 8 when none
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [3:0] m;
    logic [3:0] s;
    m = 4'h0;
    s = 4'h0;
    live = chan_req_i & ~chan_mask_i;
    s1_ir = live[9:2];
    s2_ir = live[19:12];
    master_ir_o[0] = live[0];
    master_ir_o[1] = live[1];
    master_ir_o[3] = live[10];
    master_ir_o[4] = live[11];
    master_ir_o[6] = live[20];
    master_ir_o[7] = live[21];
    // fixed cascade wiring; bypass when slave off
    master_ir_o[ISR_MASTER_SLAVE1_IR] = cascade_i.slave1_off ? live[2] : |s1_ir;
    master_ir_o[ISR_MASTER_SLAVE2_IR] = cascade_i.slave2_off ? live[12] : |s2_ir;
    winner_o = 5'h00;
    m = first_set(master_ir_o);
    case (m)
      4'h0: winner_o = 5'd1;
      4'h1: winner_o = 5'd2;
      4'h2: begin
        s = first_set(s1_ir);
        winner_o = cascade_i.slave1_off ? 5'd3 : 5'(s) + 5'd3;
      end
      4'h3: winner_o = 5'd11;
      4'h4: winner_o = 5'd12;
      4'h5: begin
        s = first_set(s2_ir);
        winner_o = cascade_i.slave2_off ? 5'd13 : 5'(s) + 5'd13;
      end
      4'h6: winner_o = 5'd21;
      4'h7: winner_o = 5'd22;
      default: winner_o = 5'h00;
    endcase
  end

endmodule

// file: tb/isr_top_sva.sv
`timescale 1ns/1ns
module isr_top_chk
  import isr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic [ISR_NUM_CHAN-1:0] chan_mask_i,
  input wire isr_pkg::isr_cascade_t cascade_i,
  input wire isr_pkg::isr_mmcr_req_t mmcr_i,
  input wire isr_pkg::isr_io_req_t io_i,
  input wire logic mmcr_rvalid_o,
  input wire logic [ISR_NUM_CHAN-1:0] chan_req_o,
  input wire logic [7:0] master_ir_o,
  input wire logic cpu_intr_o,
  input wire logic [4:0] active_chan_o,
  input wire logic nmi_req_o,
  input wire logic ignne_o
);
  logic [21:0] eff;
  logic [7:0] mir;
  logic [4:0] win;
  // bypassed slave passes only its first channel
  always_comb begin
    eff = chan_req_o & ~chan_mask_i;
    if (cascade_i.slave1_off) begin
      eff[9:3] = '0;
    end
    if (cascade_i.slave2_off) begin
      eff[19:13] = '0;
    end
    mir = {eff[21], eff[20], |eff[19:12], eff[11], eff[10], |eff[9:2], eff[1], eff[0]};
    win = 5'h00;
    for (int i = 21; i >= 0; i--) begin
      if (eff[i]) begin
        win = 5'(i + 1);
      end
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_low;
    mmcr_i.wr && mmcr_i.addr == ISR_SW_TRIG_LOW_OFS;
  endsequence
  sequence s_wr_high;
    mmcr_i.wr && mmcr_i.addr == ISR_SW_TRIG_HIGH_OFS;
  endsequence
  chk_low_trig_req: assert property (
    s_wr_low |-> ##2 (chan_req_o[15:0] & $past(mmcr_i.wdata, 2)) == $past(mmcr_i.wdata, 2))
    else $error("low trigger not seen");
  chk_high_trig_req: assert property (
    s_wr_high |-> ##2 (chan_req_o[21:16] & $past(mmcr_i.wdata[5:0], 2))
      == $past(mmcr_i.wdata[5:0], 2))
    else $error("high trigger not seen");
  chk_nmi_trig: assert property (
    s_wr_high ##0 mmcr_i.wdata[6] |-> ##2 nmi_req_o)
    else $error("nmi trigger not seen");
  chk_cpu_any: assert property (
    cpu_intr_o == $past(win != 5'h00))
    else $error("cpu request wrong");
  chk_fixed_prio: assert property (
    active_chan_o == $past(win))
    else $error("winner wrong");
  chk_master_wiring: assert property (
    master_ir_o == $past(mir))
    else $error("master inputs wrong");
  chk_read_answer: assert property (
    mmcr_rvalid_o == $past(mmcr_i.rd))
    else $error("read answer timing wrong");
  chk_clear_ignne: assert property (
    io_i.wr && io_i.addr == ISR_FPU_CLR_PORT |=> ignne_o)
    else $error("ignne not forced");
endmodule
bind isr_top isr_top_chk i_isr_top_chk (
  .core_clk_i, .rst_n_i, .chan_mask_i, .cascade_i, .mmcr_i, .io_i, .mmcr_rvalid_o,
  .chan_req_o, .master_ir_o, .cpu_intr_o, .active_chan_o, .nmi_req_o, .ignne_o
);

// file: tb/isr_cpu_model.sv
`timescale 1ns/1ns
module isr_cpu_model (
  // clock
  input wire logic core_clk_i,
  // from the router
  input wire logic cpu_intr_i,
  input wire logic [4:0] active_chan_i,
  // numeric fault, set by the bench
  input wire logic fault_i,
  output logic ferr_o,
  output logic [4:0] taken_o
);
  // error pin stays up until the handler clears the fault
  assign ferr_o = fault_i;
  always_ff @(posedge core_clk_i) begin
    if (cpu_intr_i) begin
      taken_o <= active_chan_i;
    end
  end
endmodule

// file: tb/test_interrupt_source_router.sv
`timescale 1ns/1ns
module test_interrupt_source_router;
  import isr_pkg::*;
  logic clk, rst_n, fault, ferr, rvalid, intr, nmi, ignne;
  logic [14:0] pins, inv;
  logic [18:0] isrc;
  isr_route_t [ISR_NUM_SRC-1:0] route;
  logic [21:0] mask, req;
  isr_cascade_t casc;
  isr_mmcr_req_t mmcr;
  isr_io_req_t io;
  logic [15:0] rdata, d;
  logic [7:0] mir;
  logic [4:0] act, taken, e;
  logic [31:0] seed, w;
  int bad_count, checked;
  int tsrc[7] = '{3, 1, 3, 2, 2, 0, 0};
  logic [4:0] tcode[7] = '{5'h05, 5'h07, 5'h1f, 5'h1f, 5'h04, 5'h1f, 5'h1e};
  logic [21:0] tch[7] = '{0, 0, 0, 0, 22'h8, 0, 0};
  logic [6:0] tnmi = 7'b010_0100;
  isr_top i_isr_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .general_irq_pins_i(pins[10:0]),
    .pci_int_pins_i(pins[14:11]), .internal_src_i(isrc), .ferr_i(ferr),
    .source_routing_fields_i(route), .ext_invert_i(inv), .chan_mask_i(mask),
    .cascade_i(casc), .mmcr_i(mmcr), .io_i(io), .mmcr_rdata_o(rdata),
    .mmcr_rvalid_o(rvalid), .chan_req_o(req), .master_ir_o(mir), .cpu_intr_o(intr),
    .active_chan_o(act), .nmi_req_o(nmi), .ignne_o(ignne));
  isr_cpu_model i_isr_cpu_model (.core_clk_i(clk), .cpu_intr_i(intr),
    .active_chan_i(act), .fault_i(fault), .ferr_o(ferr), .taken_o(taken));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] exp_act(logic [21:0] r);
    logic [4:0] n;
    r &= ~mask;
    if (casc.slave1_off) r[9:3] = '0;
    if (casc.slave2_off) r[19:13] = '0;
    n = 5'h00;
    for (int i = 21; i >= 0; i--) if (r[i]) n = 5'(i + 1);
    return n;
  endfunction
  function automatic logic [7:0] exp_mir(logic [21:0] r);
    r &= ~mask;
    if (casc.slave1_off) r[9:3] = '0;
    if (casc.slave2_off) r[19:13] = '0;
    return {r[21], r[20], |r[19:12], r[11], r[10], |r[9:2], r[1], r[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fail(string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_ch(logic [21:0] g, logic [21:0] x);
    checked++;
    if (g !== x) fail($sformatf("channels %h not %h", g, x));
  endtask
  task automatic cmp_val(logic [15:0] g, logic [15:0] x);
    checked++;
    if (g !== x) fail($sformatf("value %h not %h", g, x));
  endtask
  task automatic cmp_bit(logic g, logic x);
    checked++;
    if (g !== x) fail($sformatf("flag %b not %b", g, x));
  endtask
  task automatic mwr(logic [11:0] a, logic [15:0] v);
    mmcr = '{1'b1, 1'b0, a, v};
    tick(1);
    mmcr = '0;
    tick(1);
  endtask
  task automatic mrd(logic [11:0] a);
    mmcr = '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    mmcr = '0;
    if (rvalid !== 1'b1) fail("no read answer");
    d = rdata;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    seed = 32'h0000_000a;
    rst_n = 1'b0;
    fault = 1'b0;
    pins = '0;
    inv = '0;
    isrc = '0;
    route = '0;
    mask = '0;
    casc = '0;
    mmcr = '0;
    io = '0;
    bad_count = 0;
    checked = 0;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    mrd(ISR_SW_TRIG_LOW_OFS);
    cmp_val(d, ISR_SW_LOW_RST);
    mrd(ISR_SW_TRIG_HIGH_OFS);
    cmp_val(d, {9'h000, ISR_SW_HIGH_RST});
    cmp_ch(req, '0);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0020_0000 : rnd();
      mask = 22'(rnd());
      casc = 2'(rnd());
      mwr(ISR_SW_TRIG_LOW_OFS, w[15:0]);
      mwr(ISR_SW_TRIG_HIGH_OFS, w[31:16]);
      mrd(ISR_SW_TRIG_HIGH_OFS);
      tick(1);
      cmp_val(d, {9'h000, w[22:16]});
      cmp_ch(req, w[21:0]);
      cmp_bit(nmi, w[22]);
      e = exp_act(w[21:0]);
      cmp_val(16'(act), 16'(e));
      cmp_bit(intr, e != 5'h00);
      cmp_val(16'(mir), 16'(exp_mir(w[21:0])));
      if (e != 5'h00) cmp_val(16'(taken), 16'(e));
    end
    mwr(ISR_SW_TRIG_LOW_OFS, 16'h0000);
    mwr(ISR_SW_TRIG_HIGH_OFS, 16'h0000);
    mask = '0;
    casc = '0;
    $display("trigger test done");
    for (int c = 1; c <= 22; c++) begin
      w = 4 + rnd() % 14;
      route[15 + w] = 5'(c);
      isrc[w] = 1'b1;
      tick(3);
      cmp_ch(req, 22'(1) << (c - 1));
      cmp_val(16'(act), 16'(c));
      isrc[w] = 1'b0;
      route[15 + w] = ISR_ROUTE_NONE;
      tick(1);
    end
    for (int i = 0; i < 7; i++) begin
      route[15 + tsrc[i]] = tcode[i];
      isrc[tsrc[i]] = 1'b1;
      tick(3);
      cmp_ch(req, tch[i]);
      cmp_bit(nmi, tnmi[i]);
      isrc[tsrc[i]] = 1'b0;
      route[15 + tsrc[i]] = ISR_ROUTE_NONE;
      tick(1);
    end
    $display("routing test done");
    for (int k = 0; k < 15; k++) route[k] = 5'(k + 1);
    repeat (3) begin
      pins = 15'(rnd());
      inv = 15'(rnd());
      tick(5);
      cmp_ch(req, {7'h00, pins ^ inv});
    end
    route = '0;
    tick(5);
    cmp_ch(req, '0);
    $display("polarity test done");
    route[33] = 5'd8;
    fault = 1'b1;
    tick(6);
    cmp_ch(req, 22'h00_0080);
    io = '{1'b1, 16'h00f1, 8'h00};
    tick(1);
    io = '{1'b1, ISR_FPU_CLR_PORT, 8'h00};
    cmp_bit(ignne, 1'b0);
    tick(1);
    io = '0;
    cmp_bit(ignne, 1'b1);
    tick(2);
    cmp_ch(req, '0);
    fault = 1'b0;
    w = 0;
    while (ignne === 1'b1 && w < 8) begin
      tick(1);
      w++;
    end
    if (w == 8) begin
      fail("ignne stuck");
      finish_test();
    end
    cmp_val(w[15:0], 16'h0003);
    mwr(ISR_SW_TRIG_LOW_OFS, 16'h00ff);
    fault = 1'b1;
    tick(6);
    io = '{1'b1, ISR_FPU_CLR_PORT, 8'h00};
    tick(1);
    io = '0;
    rst_n = 1'b0;
    tick(1);
    cmp_bit(ignne, 1'b0);
    cmp_ch(req, '0);
    fault = 1'b0;
    rst_n = 1'b1;
    tick(5);
    cmp_ch(req, '0);
    cmp_bit(ignne, 1'b0);
    mrd(ISR_SW_TRIG_LOW_OFS);
    cmp_val(d, ISR_SW_LOW_RST);
    $display("fpu test done");
    finish_test();
  end
endmodule
